// File: bench/bibo_eeprom_model.sv
// Serial EEPROM loader model for the bus options register
`timescale 1ns/1ns
`default_nettype none
module bibo_eeprom_model #(
  // Stored image, reserved bits set on purpose to exercise masking
  parameter logic [31:0] IMAGE = 32'h0f0f_3fc9
) (
  input wire logic clk_i,
  input wire logic go_i,
  output logic present_o,
  output logic load_o,
  output logic [31:0] data_o
);
  assign present_o = 1'b1;
  // Outside the load pulse the data lines show garbage, not the image
  assign data_o = load_o ? IMAGE : ~IMAGE;
  always_ff @(posedge clk_i)
    load_o <= go_i;
endmodule : bibo_eeprom_model
`default_nettype wire

// File: bench/bibo_regs_tb.sv
// Self-checking bench for the bus options and unique identifier registers
`timescale 1ns/1ns
`default_nettype none
module bibo_regs_tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic soft_i = 1'b0, wp_i = 1'b0, romc_i = 1'b0, bres_i = 1'b0, ee_go = 1'b0;
  bibo_pkg::bibo_reg_req_s req = '0;
  bibo_pkg::bibo_rx_req_s rxr = '0;
  bibo_pkg::bibo_rx_pkt_s rxp = '0;
  logic [31:0] rdata, q2, q3, q4, ee_data, opt, lf = 32'h3b78;
  logic ee_pres, ee_load, ack_err, rej, ee_off = 1'b0;
  int error_cnt = 0;
  int checked = 0;
  initial forever #5 clk_i = ~clk_i;
  bibo_eeprom_model u_ee (.clk_i(clk_i), .go_i(ee_go), .present_o(ee_pres),
    .load_o(ee_load), .data_o(ee_data));
  bibo_regs u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .soft_reset_i(soft_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .eeprom_present_i(ee_pres && !ee_off), .eeprom_load_i(ee_load),
    .eeprom_bus_options_i(ee_data), .rate_wp_i(wp_i), .rom_changed_i(romc_i),
    .bus_reset_i(bres_i), .rx_req_i(rxr), .rx_pkt_i(rxp), .ack_type_error_o(ack_err),
    .rate_reject_o(rej), .bib_quad2_o(q2), .bib_quad3_o(q3), .bib_quad4_o(q4));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic sr);
    @(posedge clk_i);
    req <= '{wr: 1'b1, addr: a, wdata: d};
    soft_i <= sr;
    @(posedge clk_i);
    req.wr <= 1'b0;
    soft_i <= 1'b0;
    #1;
  endtask : wr
  // Reference write: reserved bits dropped, rate only lowered when unprotected
  task automatic opt_wr(input logic [31:0] d);
    logic [31:0] n;
    n = d & 32'hf8ff_f0c7;
    if (wp_i || n[2:0] > opt[2:0])
      n[2:0] = opt[2:0];
    opt = n;
  endtask : opt_wr
  task automatic rx(input logic [15:0] len, input logic ph, input logic [2:0] sp);
    int lim;
    lim = 2 << opt[15:12];
    @(posedge clk_i);
    rxr <= '{blk_wr: 1'b1, phys_handled: ph, length: len};
    rxp <= '{valid: 1'b1, speed: sp};
    @(posedge clk_i);
    rxr <= '0;
    rxp <= '0;
    #1;
    chk({31'h0, ack_err}, 32'(int'(len) > lim && !ph));
    chk({31'h0, rej}, 32'(sp > opt[2:0]));
  endtask : rx
  initial
  begin
    #200000;
    error_cnt++;
    conclude();
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    opt = 32'h0000_9002;
    chk(q2, opt);
    chk(q3 | q4, 32'h0);
    rx(16'd1025, 1'b0, 3'h2);
    rx(16'd1024, 1'b0, 3'h3);
    $display("test reset done");
    wr(bibo_pkg::BUS_OPTIONS_OFS, 32'h0000_2001, 1'b0);
    opt_wr(32'h0000_2001);
    wr(bibo_pkg::BUS_OPTIONS_OFS, 32'h0000_2002, 1'b0);
    opt_wr(32'h0000_2002);
    chk(q2, opt);
    rx(16'd9, 1'b0, 3'h2);
    rx(16'd9, 1'b1, 3'h1);
    rx(16'd8, 1'b0, 3'h0);
    $display("test limits done");
    for (int i = 0; i < 12; i++)
    begin
      lf = lfsr(lf);
      wp_i <= lf[5];
      wr(bibo_pkg::BUS_OPTIONS_OFS, {lf[31:16], 4'h3, lf[11:0]}, 1'b0);
      opt_wr({lf[31:16], 4'h3, lf[11:0]});
      chk(q2, opt);
      chk(rdata, opt);
    end
    wp_i <= 1'b0;
    wr(bibo_pkg::BUS_OPTIONS_OFS, 32'h0, 1'b1);
    chk(q2 & 32'hffff_fff8, opt & 32'hffff_fff8);
    // Rate is undefined after soft reset; only that field follows the design
    opt[2:0] = q2[2:0];
    $display("test options done");
    wr(bibo_pkg::UNIQUE_ID_HIGH_OFS, lf, 1'b0);
    wr(bibo_pkg::UNIQUE_ID_LOW_OFS, ~lf, 1'b0);
    chk(q3, lf);
    chk(q4, ~lf);
    chk(rdata, ~lf);
    wr(8'h2c, lf, 1'b0);
    chk(rdata, 32'h0);
    $display("test ids done");
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk_i);
      romc_i <= i < 5;
      @(posedge clk_i);
      romc_i <= 1'b0;
      bres_i <= 1'b1;
      @(posedge clk_i);
      bres_i <= 1'b0;
      #1;
      opt[7:6] = opt[7:6] + 2'(i < 5);
      chk(q2, opt);
    end
    // First pulse with no EEPROM fitted must be ignored
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_i);
      ee_off <= (k == 0);
      ee_go <= 1'b1;
      @(posedge clk_i);
      ee_go <= 1'b0;
      @(posedge clk_i);
      #1;
      if (k == 1)
        opt = 32'h0f0f_3fc9 & 32'hf8ff_f0c7;
      chk(q2, opt);
    end
    $display("test tally and load done");
    conclude();
  end
endmodule : bibo_regs_tb
`default_nettype wire

// File: rtl/bibo_pkg.sv
// Package: constants and types for the bus information block option registers
package bibo_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] BUS_OPTIONS_OFS = 8'h20;
  localparam logic [7:0] UNIQUE_ID_HIGH_OFS = 8'h24;
  localparam logic [7:0] UNIQUE_ID_LOW_OFS = 8'h28;

  // ****************************************
  // Bus options field positions
  // ****************************************
  localparam int ISO_CAP_BIT = 29;
  localparam int BUS_MGR_CAP_BIT = 28;
  localparam int PWR_MGR_CAP_BIT = 27;
  localparam int CYC_ACC_LSB = 16;
  localparam int MAX_PAYLOAD_LSB = 12;
  localparam int ROM_TALLY_LSB = 6;
  localparam int NODE_RATE_LSB = 0;
  // Writable bits: 31:27, 23:16, 15:12, 7:6, 2:0
  localparam logic [31:0] BUS_OPTIONS_WMASK = 32'hf8ff_f0c7;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0] MAX_PAYLOAD_1024 = 4'h9;
  localparam logic [2:0] RATE_100 = 3'h0;
  localparam logic [2:0] RATE_200 = 3'h1;
  localparam logic [2:0] RATE_400 = 3'h2;
  localparam logic [31:0] UNIQUE_ID_RESET = 32'h0000_0000;
  localparam logic [31:0] BUS_OPTIONS_RESET = 32'h0000_9002;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bibo_reg_req_s;

  typedef struct packed {
    logic blk_wr;
    logic phys_handled;
    logic [15:0] length;
  } bibo_rx_req_s;

  typedef struct packed {
    logic valid;
    logic [2:0] speed;
  } bibo_rx_pkt_s;
endpackage : bibo_pkg

// File: rtl/bibo_regs.sv
// Bus information block option and unique identifier registers
`timescale 1ns/1ns
`default_nettype none
module bibo_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic soft_reset_i,
  // Register port
  input wire bibo_pkg::bibo_reg_req_s reg_req_i,
  output logic [31:0] reg_rdata_o,
  // Serial EEPROM loader
  input wire logic eeprom_present_i,
  input wire logic eeprom_load_i,
  input wire logic [31:0] eeprom_bus_options_i,
  // Vendor control rate write protect
  input wire logic rate_wp_i,
  // Configuration ROM events
  input wire logic rom_changed_i,
  input wire logic bus_reset_i,
  // Receive checks
  input wire bibo_pkg::bibo_rx_req_s rx_req_i,
  input wire bibo_pkg::bibo_rx_pkt_s rx_pkt_i,
  output logic ack_type_error_o,
  output logic rate_reject_o,
  // Bus information block quadlets
  output logic [31:0] bib_quad2_o,
  output logic [31:0] bib_quad3_o,
  output logic [31:0] bib_quad4_o
);
  // ****************************************
  // Reset release
  // ****************************************
  logic rst_s1_reg;
  logic rstn_sync_reg;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_s1_reg <= 1'b0;
      rstn_sync_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rstn_sync_reg <= rst_s1_reg;
    end
  end

  // ****************************************
  // Decode
  // ****************************************
  function automatic logic [16:0] payload_bytes(input logic [3:0] code);
    // Five-bit exponent so that code 15 gives 64 KiB rather than wrapping
    payload_bytes = 17'h1 << ({1'b0, code} + 5'h01);
  endfunction : payload_bytes

  logic [31:0] opts_reg, opts_next;
  logic [31:0] uid_hi_reg, uid_lo_reg;
  logic changed_reg;
  logic ack_err_reg, rate_rej_reg;

  wire wr_opts = reg_req_i.wr && (reg_req_i.addr == bibo_pkg::BUS_OPTIONS_OFS);
  wire wr_uid_hi = reg_req_i.wr && (reg_req_i.addr == bibo_pkg::UNIQUE_ID_HIGH_OFS);
  wire wr_uid_lo = reg_req_i.wr && (reg_req_i.addr == bibo_pkg::UNIQUE_ID_LOW_OFS);
  wire eeprom_take = eeprom_load_i && eeprom_present_i;
  wire [2:0] cur_rate = opts_reg[bibo_pkg::NODE_RATE_LSB +: 3];
  wire [2:0] new_rate = reg_req_i.wdata[bibo_pkg::NODE_RATE_LSB +: 3];
  // Only lower or keep, and only while rate_wp_i is low
  wire rate_ok = !rate_wp_i && (new_rate <= cur_rate);
  wire [1:0] tally = opts_reg[bibo_pkg::ROM_TALLY_LSB +: 2];
  wire [31:0] wr_val = reg_req_i.wdata & bibo_pkg::BUS_OPTIONS_WMASK;

  // ****************************************
  // Bus options next value
  // ****************************************
  always_comb
  begin
    opts_next = opts_reg;
    if (eeprom_take)
    begin
      opts_next = eeprom_bus_options_i & bibo_pkg::BUS_OPTIONS_WMASK;
    end
    else if (soft_reset_i)
    begin
      // Payload and rate both kept; rate is undefined, holding is simplest
      opts_next = opts_reg;
    end
    else
    begin
      if (wr_opts)
      begin
        opts_next = {wr_val[31:3], rate_ok ? new_rate : cur_rate};
      end
      if (bus_reset_i && (changed_reg || rom_changed_i))
      begin
        opts_next[bibo_pkg::ROM_TALLY_LSB +: 2] = tally + 2'h1;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i or negedge rstn_sync_reg)
  begin
    if (!rstn_sync_reg)
    begin
      opts_reg <= bibo_pkg::BUS_OPTIONS_RESET;
      uid_hi_reg <= bibo_pkg::UNIQUE_ID_RESET;
      uid_lo_reg <= bibo_pkg::UNIQUE_ID_RESET;
      changed_reg <= 1'b0;
      ack_err_reg <= 1'b0;
      rate_rej_reg <= 1'b0;
    end
    else
    begin
      opts_reg <= opts_next;
      if (wr_uid_hi)
      begin
        uid_hi_reg <= reg_req_i.wdata;
      end
      if (wr_uid_lo)
      begin
        uid_lo_reg <= reg_req_i.wdata;
      end
      // A change in the bus reset cycle is counted there unless a soft reset or EEPROM load takes that cycle
      changed_reg <= rom_changed_i ? !bus_reset_i : (changed_reg && !bus_reset_i);
      ack_err_reg <= rx_req_i.blk_wr && !rx_req_i.phys_handled
        && ({1'b0, rx_req_i.length} > payload_bytes(opts_reg[bibo_pkg::MAX_PAYLOAD_LSB +: 4]));
      rate_rej_reg <= rx_pkt_i.valid && (rx_pkt_i.speed > cur_rate);
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Physically handled oversize requests are accepted, the permitted choice
  assign ack_type_error_o = ack_err_reg;
  assign rate_reject_o = rate_rej_reg;
  assign bib_quad2_o = opts_reg;
  assign bib_quad3_o = uid_hi_reg;
  assign bib_quad4_o = uid_lo_reg;

  always_comb
  begin
    case (reg_req_i.addr)
      bibo_pkg::BUS_OPTIONS_OFS: reg_rdata_o = opts_reg;
      bibo_pkg::UNIQUE_ID_HIGH_OFS: reg_rdata_o = uid_hi_reg;
      bibo_pkg::UNIQUE_ID_LOW_OFS: reg_rdata_o = uid_lo_reg;
      default: reg_rdata_o = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_sync_reg);

  a_payload_soft_hold: assert property (soft_reset_i && !eeprom_take |=>
    $stable(opts_reg[bibo_pkg::MAX_PAYLOAD_LSB +: 4]))
    else $error("payload field changed on soft reset");
  a_rate_wp_block: assert property (wr_opts && rate_wp_i && !eeprom_take |=>
    $stable(opts_reg[2:0]))
    else $error("rate changed while protected");
  a_rate_never_up: assert property (!eeprom_take |=>
    opts_reg[2:0] <= $past(opts_reg[2:0]))
    else $error("rate raised by software");
  a_rate_legal: assert property (opts_reg[2:0] <= bibo_pkg::RATE_400 || $past(eeprom_take))
    else $error("reserved rate code");
  a_oversize_ack: assert property (rx_req_i.blk_wr && !rx_req_i.phys_handled
    && rx_req_i.length > 16'(payload_bytes(opts_reg[15:12])) && opts_reg[15:12] < 4'hf
    |=> ack_type_error_o)
    else $error("oversized write not refused");
  a_rate_reject: assert property (rx_pkt_i.valid && rx_pkt_i.speed > opts_reg[2:0]
    |=> rate_reject_o ##1 !rate_reject_o || $past(rx_pkt_i.valid, 1))
    else $error("fast packet not rejected");
  a_tally_incr: assert property (bus_reset_i && changed_reg && !eeprom_take && !soft_reset_i
    |=> opts_reg[7:6] == $past(opts_reg[7:6]) + 2'h1)
    else $error("tally not incremented");
  a_tally_hold: assert property (!rom_changed_i && !changed_reg && !wr_opts && !eeprom_take
    |=> $stable(opts_reg[7:6]))
    else $error("tally moved without change");
  a_rsvd_zero: assert property ((bib_quad2_o & ~bibo_pkg::BUS_OPTIONS_WMASK) == 32'h0)
    else $error("reserved option bits set");
  a_uid_quads: assert property (wr_uid_hi |=> bib_quad3_o == $past(reg_req_i.wdata))
    else $error("high identifier not served");
endmodule : bibo_regs
`default_nettype wire
